// >>> hw/dmem_bank_core.sv
// Data-memory address generator, pointer file, bank select and ALU flags.
// Assumes the core decoder issues at most one access per clock and an
// APB master reaches the control registers; all in one clock domain.
`timescale 1ns/1ps
module dmem_bank_core (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire dmem_pkg::core_req_t req_i,
    output logic [7:0] rdata_o,
    output logic rvalid_o,
    output logic [11:0] addr_o,
    output logic [7:0] flags_o,
    input wire logic [11:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    input wire logic [3:0] pstrb_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o
);
    logic [3:0] bank_sel;
    logic [11:0] fp [dmem_pkg::NUM_PTR];
    logic [7:0] ram [dmem_pkg::RAM_BYTES];
    logic [11:0] next_fp [dmem_pkg::NUM_PTR];
    logic [4:0] next_flags;

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // direct address forming
    wire logic [11:0] win_addr;
    wire logic [11:0] direct_addr;
    assign win_addr = (req_i.offset < dmem_pkg::WINDOW_SPLIT)
        ? {dmem_pkg::BANK_LOW, req_i.offset}
        : {dmem_pkg::BANK_SFR, req_i.offset};
    assign direct_addr = req_i.move ? req_i.full_addr
        : req_i.access_bit ? {bank_sel, req_i.offset}
        : win_addr;

    // pointer port decode of the direct address
    wire logic [11:0] d_rel;
    wire logic d_in;
    wire logic [1:0] d_ptr;
    wire logic [2:0] mode;
    wire logic d_port;
    assign d_rel = direct_addr - dmem_pkg::PORT_BASE;
    assign d_in = direct_addr >= dmem_pkg::PORT_BASE
        && direct_addr < dmem_pkg::PORT_END;
    assign d_ptr = d_rel[dmem_pkg::PTR_MSB:dmem_pkg::PTR_LSB];
    assign mode = d_rel[dmem_pkg::SLOT_MSB:0];
    assign d_port = d_in && mode < dmem_pkg::SLOT_LOW;

    // indirect target and pointer step
    wire logic [11:0] fp_sel;
    wire logic [11:0] acc_ext;
    wire logic [11:0] ind_addr;
    wire logic [11:0] step_val;
    wire logic do_step;
    wire logic [11:0] tgt;
    assign fp_sel = (d_ptr < dmem_pkg::PTR_COUNT) ? fp[d_ptr] : '0;
    assign acc_ext = {{dmem_pkg::EXT_W{
        req_i.accumulator[dmem_pkg::SIGN_BIT]}}, req_i.accumulator};
    assign ind_addr =
        (mode == dmem_pkg::MODE_PREINC) ? fp_sel + dmem_pkg::ONE12
        : (mode == dmem_pkg::MODE_INDEXED) ? fp_sel + acc_ext
        : fp_sel;
    // full 12-bit arithmetic so low-byte carry reaches the high nibble
    assign step_val = (mode == dmem_pkg::MODE_POSTDEC)
        ? fp_sel - dmem_pkg::ONE12
        : fp_sel + dmem_pkg::ONE12;
    assign do_step = req_i.valid && d_port
        && (mode == dmem_pkg::MODE_POSTDEC
        || mode == dmem_pkg::MODE_POSTINC
        || mode == dmem_pkg::MODE_PREINC);
    assign tgt = d_port ? ind_addr : direct_addr;

    // decode of the final target
    wire logic [11:0] t_rel;
    wire logic t_in;
    wire logic [1:0] t_ptr;
    wire logic [2:0] t_slot;
    wire logic t_port;
    wire logic ind_loop;
    wire logic t_fp_lo;
    wire logic t_fp_hi;
    wire logic [11:0] fp_t;
    wire logic ram_hit;
    wire logic [8:0] ram_idx;
    wire logic core_wr;
    assign t_rel = tgt - dmem_pkg::PORT_BASE;
    assign t_in = tgt >= dmem_pkg::PORT_BASE && tgt < dmem_pkg::PORT_END;
    assign t_ptr = t_rel[dmem_pkg::PTR_MSB:dmem_pkg::PTR_LSB];
    assign t_slot = t_rel[dmem_pkg::SLOT_MSB:0];
    assign t_port = t_in && t_slot < dmem_pkg::SLOT_LOW;
    assign ind_loop = d_port && t_port;
    assign t_fp_lo = t_in && t_slot == dmem_pkg::SLOT_LOW;
    assign t_fp_hi = t_in && t_slot == dmem_pkg::SLOT_HIGH;
    assign fp_t = (t_ptr < dmem_pkg::PTR_COUNT) ? fp[t_ptr] : '0;
    // addresses from RAM_END up, except the pointer byte, status and bank select registers, read zero and swallow writes
    assign ram_hit = tgt < dmem_pkg::RAM_END;
    assign ram_idx = tgt[dmem_pkg::RAM_IDX_W-1:0];
    assign core_wr = req_i.valid && req_i.write && !ind_loop;

    // read data path
    wire logic [7:0] rd_val;
    assign rd_val = t_port ? 8'h00
        : t_fp_lo ? fp_t[7:0]
        : t_fp_hi ? {4'h0, fp_t[dmem_pkg::BANK_MSB:dmem_pkg::BANK_LSB]}
        : (tgt == dmem_pkg::STATUS_ADDR) ? flags_o
        : (tgt == dmem_pkg::BANK_SEL_ADDR) ? {4'h0, bank_sel}
        : ram_hit ? ram[ram_idx]
        : 8'h00;

    // flag computation
    wire logic sub_op;
    wire logic arith_op;
    wire logic [7:0] b_eff;
    wire logic [8:0] sum9;
    wire logic [4:0] half5;
    wire logic [7:0] alu_res;
    wire logic [4:0] alu_val;
    wire logic [4:0] kind_mask;
    wire logic alu_on;
    wire logic [4:0] alu_mask;
    assign sub_op = req_i.kind == dmem_pkg::ALU_SUB;
    assign arith_op = sub_op || req_i.kind == dmem_pkg::ALU_ADD;
    // subtract is add of the two's complement, so carry means no borrow
    assign b_eff = sub_op ? ~req_i.opb : req_i.opb;
    assign sum9 = {1'b0, req_i.opa} + {1'b0, b_eff} + {8'h00, sub_op};
    assign half5 = {1'b0, req_i.opa[3:0]} + {1'b0, b_eff[3:0]}
        + {4'h0, sub_op};
    assign alu_res = arith_op ? sum9[7:0]
        : (req_i.kind == dmem_pkg::ALU_ROTL)
            ? {req_i.opa[6:0], req_i.opa[7]}
        : (req_i.kind == dmem_pkg::ALU_ROTR)
            ? {req_i.opa[0], req_i.opa[7:1]}
        : req_i.result;
    assign alu_val[dmem_pkg::FLAG_N] = alu_res[dmem_pkg::SIGN_BIT];
    assign alu_val[dmem_pkg::FLAG_OV] = arith_op
        && (req_i.opa[7] == b_eff[7])
        && (alu_res[7] != req_i.opa[7]);
    assign alu_val[dmem_pkg::FLAG_Z] = alu_res == 8'h00;
    assign alu_val[dmem_pkg::FLAG_DC] = arith_op ? half5[4]
        : (req_i.kind == dmem_pkg::ALU_ROTL) ? req_i.opa[3]
        : req_i.opa[4];
    assign alu_val[dmem_pkg::FLAG_C] = arith_op ? sum9[8]
        : (req_i.kind == dmem_pkg::ALU_ROTL) ? req_i.opa[7]
        : req_i.opa[0];
    assign kind_mask = arith_op ? dmem_pkg::MASK_ARITH
        : (req_i.kind == dmem_pkg::ALU_LOGIC) ? dmem_pkg::MASK_LOGIC
        : (req_i.kind == dmem_pkg::ALU_NONE) ? 5'h00
        : dmem_pkg::MASK_ROT;
    assign alu_on = req_i.valid && !(ind_loop && req_i.write);
    assign alu_mask = alu_on ? kind_mask : 5'h00;

    // APB decode
    wire logic [11:0] p_rel;
    wire logic [1:0] p_idx;
    wire logic a_bank;
    wire logic a_flags;
    wire logic a_ptr;
    wire logic a_last;
    wire logic a_map;
    wire logic apb_commit;
    wire logic apb_wr;
    wire logic apb_wr_flags;
    wire logic next_pready;
    wire logic [31:0] apb_rd;
    wire logic [11:0] fp_p;
    assign p_rel = paddr_i - dmem_pkg::APB_PTR0;
    assign p_idx = p_rel[3:2];
    assign a_bank = paddr_i == dmem_pkg::APB_BANK;
    assign a_flags = paddr_i == dmem_pkg::APB_FLAGS;
    assign a_ptr = paddr_i >= dmem_pkg::APB_PTR0
        && paddr_i < dmem_pkg::APB_PTR_END && paddr_i[1:0] == 2'h0;
    assign a_last = paddr_i == dmem_pkg::APB_LAST;
    assign a_map = a_bank || a_flags || a_ptr || a_last;
    assign apb_commit = psel_i && penable_i && pready_o;
    assign apb_wr = apb_commit && pwrite_i && pstrb_i[0];
    assign apb_wr_flags = apb_wr && a_flags;
    assign next_pready = psel_i && penable_i && !pready_o;
    assign fp_p = (p_idx < dmem_pkg::PTR_COUNT) ? fp[p_idx] : '0;
    assign apb_rd = a_bank ? 32'(bank_sel)
        : a_flags ? 32'(flags_o)
        : a_ptr ? 32'(fp_p)
        : a_last ? 32'(addr_o)
        : 32'h0000_0000;

    // bank select: only the low nibble exists
    wire logic [3:0] next_bank;
    assign next_bank = (apb_wr && a_bank) ? pwdata_i[3:0]
        : (core_wr && tgt == dmem_pkg::BANK_SEL_ADDR)
            ? req_i.wdata[3:0] : bank_sel;

    always_comb
    begin
        next_flags = flags_o[dmem_pkg::FLAG_W-1:0];
        if (core_wr && tgt == dmem_pkg::STATUS_ADDR)
        begin
            next_flags = req_i.wdata[dmem_pkg::FLAG_W-1:0];
        end
        // ALU owned bits override a data write to the status register
        next_flags = (next_flags & ~alu_mask) | (alu_val & alu_mask);
        if (req_i.valid && ind_loop && !req_i.write)
        begin
            next_flags[dmem_pkg::FLAG_Z] = 1'b1;
        end
        if (apb_wr_flags)
        begin
            next_flags = pwdata_i[dmem_pkg::FLAG_W-1:0];
        end
    end

    // pointer stepping leaves flags alone; byte writes win over the step
    always_comb
    begin
        for (int i = 0; i < dmem_pkg::NUM_PTR; i++)
        begin
            next_fp[i] = fp[i];
            if (do_step && d_ptr == 2'(i))
            begin
                next_fp[i] = step_val;
            end
            if (core_wr && t_fp_lo && t_ptr == 2'(i))
            begin
                next_fp[i][7:0] = req_i.wdata;
            end
            if (core_wr && t_fp_hi && t_ptr == 2'(i))
            begin
                next_fp[i][dmem_pkg::BANK_MSB:dmem_pkg::BANK_LSB] =
                    req_i.wdata[3:0];
            end
            if (apb_wr && a_ptr && p_idx == 2'(i))
            begin
                next_fp[i][7:0] = pwdata_i[7:0];
            end
            if (apb_commit && pwrite_i && pstrb_i[1] && a_ptr
                && p_idx == 2'(i))
            begin
                next_fp[i][dmem_pkg::BANK_MSB:dmem_pkg::BANK_LSB] =
                    pwdata_i[dmem_pkg::BANK_MSB:dmem_pkg::BANK_LSB];
            end
        end
    end

    always_ff @(posedge core_clk_i)
    begin
        if (!rst_n_i)
        begin
            bank_sel <= 4'h0;
            flags_o <= 8'h00;
            fp <= '{default: '0};
            rdata_o <= 8'h00;
            rvalid_o <= 1'b0;
            addr_o <= 12'h000;
            prdata_o <= 32'h0000_0000;
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
        else
        begin
            bank_sel <= next_bank;
            flags_o <= {3'b000, next_flags};
            fp <= next_fp;
            rvalid_o <= req_i.valid && !req_i.write;
            if (req_i.valid)
            begin
                rdata_o <= rd_val;
                addr_o <= tgt;
            end
            pready_o <= next_pready;
            pslverr_o <= next_pready && !a_map;
            if (next_pready)
            begin
                prdata_o <= apb_rd;
            end
        end
    end

    // data RAM has no reset; contents are software's business
    always_ff @(posedge core_clk_i)
    begin
        if (core_wr && ram_hit)
        begin
            ram[ram_idx] <= req_i.wdata;
        end
    end

    win_low_a:
    assert property (req_i.valid && !req_i.move && !req_i.access_bit
        && req_i.offset < dmem_pkg::WINDOW_SPLIT
        |=> addr_o == {dmem_pkg::BANK_LOW, $past(req_i.offset)})
    else $error("window low part not in bank 0");
    win_high_a:
    assert property (req_i.valid && !req_i.move && !req_i.access_bit
        && req_i.offset >= dmem_pkg::WINDOW_SPLIT && !d_port
        |=> addr_o == {dmem_pkg::BANK_SFR, $past(req_i.offset)})
    else $error("window high part not in bank 15");
    bank_direct_a:
    assert property (req_i.valid && !req_i.move && req_i.access_bit
        && !d_port
        |=> addr_o == {$past(bank_sel), $past(req_i.offset)})
    else $error("banked address wrong");
    move_full_a:
    assert property (req_i.valid && req_i.move && !d_port
        |=> addr_o == $past(req_i.full_addr))
    else $error("move did not use full address");
    bank_upper_a:
    assert property (req_i.valid && !req_i.write
        && tgt == dmem_pkg::BANK_SEL_ADDR |=> rdata_o[7:4] == 4'h0)
    else $error("bank select upper nibble not zero");
    unimpl_read_a:
    assert property (req_i.valid && !req_i.write && !ram_hit
        && tgt < dmem_pkg::SFR_START |=> rvalid_o && rdata_o == 8'h00)
    else $error("unimplemented bank read not zero");
    loop_read_a:
    assert property (req_i.valid && ind_loop && !req_i.write
        && !apb_wr_flags
        |=> rdata_o == 8'h00 && flags_o[dmem_pkg::FLAG_Z])
    else $error("port loop read not zero with zero flag");
    loop_write_a:
    assert property (req_i.valid && ind_loop && req_i.write
        && !apb_wr_flags |=> flags_o == $past(flags_o))
    else $error("port loop write touched flags");
    postinc_ptr_a:
    assert property (req_i.valid && d_port
        && mode == dmem_pkg::MODE_POSTINC
        && !(core_wr && (t_fp_lo || t_fp_hi)) && !apb_commit
        |=> fp[$past(d_ptr)] == $past(fp_sel) + dmem_pkg::ONE12
        ##1 1'b1)
    else $error("post-increment wrong");
    indexed_addr_a:
    assert property (req_i.valid && d_port
        && mode == dmem_pkg::MODE_INDEXED && !apb_commit
        && !(core_wr && (t_fp_lo || t_fp_hi))
        |=> addr_o == $past(fp_sel + acc_ext)
        && fp[$past(d_ptr)] == $past(fp_sel))
    else $error("indexed access wrong or moved pointer");
    status_dest_a:
    assert property (req_i.valid && req_i.write && !ind_loop
        && tgt == dmem_pkg::STATUS_ADDR && arith_op && !apb_wr_flags
        |=> flags_o[dmem_pkg::FLAG_W-1:0] == $past(alu_val))
    else $error("status write beat arithmetic flags");
    zero_flag_a:
    assert property (req_i.valid && req_i.kind == dmem_pkg::ALU_LOGIC
        && !ind_loop && !apb_wr_flags
        |=> flags_o[dmem_pkg::FLAG_Z] == ($past(req_i.result) == 8'h00))
    else $error("zero flag wrong");

    cov_postdec_c: cover property (req_i.valid && d_port
        && mode == dmem_pkg::MODE_POSTDEC);
    cov_indexed_c: cover property (req_i.valid && d_port
        && mode == dmem_pkg::MODE_INDEXED);
    cov_loop_c: cover property (req_i.valid && ind_loop);
    cov_apb_c: cover property (apb_commit && pwrite_i ##1 psel_i);
endmodule // dmem_bank_core

// >>> hw/dmem_pkg.sv
// Constants and types for data-memory address generation and ALU flags.
// Assumes one core clock; the core decoder drives one request per cycle.
package dmem_pkg;
    localparam int ADDR_W = 12;
    localparam int BANK_MSB = 11;
    localparam int BANK_LSB = 8;
    localparam int PTR_MSB = 4;
    localparam int PTR_LSB = 3;
    localparam int SLOT_MSB = 2;
    localparam int SIGN_BIT = 7;
    localparam int EXT_W = 4;
    localparam int NUM_PTR = 3;
    localparam logic [1:0] PTR_COUNT = 2'h3;
    localparam int RAM_BYTES = 512;
    localparam int RAM_IDX_W = 9;
    localparam logic [11:0] RAM_END = 12'h0200;
    localparam logic [7:0] WINDOW_SPLIT = 8'h60;
    localparam logic [3:0] BANK_LOW = 4'h0;
    localparam logic [3:0] BANK_SFR = 4'hF;
    localparam logic [11:0] SFR_START = 12'h0F60;
    localparam logic [11:0] PORT_BASE = 12'h0FD0;
    localparam logic [11:0] PORT_END = 12'h0FE8;
    localparam logic [11:0] STATUS_ADDR = 12'h0FE8;
    localparam logic [11:0] BANK_SEL_ADDR = 12'h0FE9;
    localparam logic [11:0] ONE12 = 12'h001;
    localparam logic [2:0] MODE_PLAIN = 3'h0;
    localparam logic [2:0] MODE_POSTDEC = 3'h1;
    localparam logic [2:0] MODE_POSTINC = 3'h2;
    localparam logic [2:0] MODE_PREINC = 3'h3;
    localparam logic [2:0] MODE_INDEXED = 3'h4;
    localparam logic [2:0] SLOT_LOW = 3'h5;
    localparam logic [2:0] SLOT_HIGH = 3'h6;
    localparam int FLAG_W = 5;
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam logic [4:0] MASK_ARITH = 5'h1F;
    localparam logic [4:0] MASK_LOGIC = 5'h14;
    localparam logic [4:0] MASK_ROT = 5'h17;
    localparam logic [11:0] APB_BANK = 12'h000;
    localparam logic [11:0] APB_FLAGS = 12'h004;
    localparam logic [11:0] APB_PTR0 = 12'h008;
    localparam logic [11:0] APB_PTR_END = 12'h014;
    localparam logic [11:0] APB_LAST = 12'h014;
    typedef enum logic [2:0] {
        ALU_NONE = 3'h0,
        ALU_ADD = 3'h1,
        ALU_SUB = 3'h2,
        ALU_LOGIC = 3'h3,
        ALU_ROTL = 3'h4,
        ALU_ROTR = 3'h5
    } alu_kind_t;
    typedef struct packed {
        logic valid;
        logic move;
        logic access_bit;
        logic write;
        logic [7:0] offset;
        logic [11:0] full_addr;
        logic [7:0] wdata;
        logic [7:0] accumulator;
        alu_kind_t kind;
        logic [7:0] opa;
        logic [7:0] opb;
        logic [7:0] result;
    } core_req_t;
endpackage

// >>> test/core_model.sv
// Behavioural model of the core decoder and ALU driving the access port.
// Assumes the block takes one access per clock with no stall.
`timescale 1ns/1ps
module core_model (
    input wire logic core_clk_i,
    output dmem_pkg::core_req_t req_o
);
    initial req_o = '0;

    // one-cycle access; fields are scrambled between pulses so that a
    // stale operand can never look like a correct answer
    task automatic send(input dmem_pkg::core_req_t r);
        dmem_pkg::core_req_t idle;
        idle = ~r;
        idle.valid = 1'b0;
        r.valid = 1'b1;
        @(posedge core_clk_i);
        req_o <= r;
        @(posedge core_clk_i);
        req_o <= idle;
    endtask
endmodule // core_model

// >>> test/tb_data_memory_banking_indirect_status.sv
// Self-checking bench for data-memory addressing, pointers and flags.
// Assumes core_model drives the access port and APB reaches registers.
`timescale 1ns/1ps
`define CHK(nm, ex, gt) \
    begin \
        tests_run++; \
        if ((gt) !== (ex)) \
        begin \
            n_mismatch++; \
            $display("CHECK FAILED %s exp %h got %h", nm, ex, gt); \
        end \
    end
module tb_data_memory_banking_indirect_status;
    logic clk;
    logic rst_n;
    dmem_pkg::core_req_t req;
    logic [7:0] rdata;
    logic rvalid;
    logic [11:0] addr;
    logic [7:0] flags;
    logic [11:0] paddr;
    logic psel;
    logic penable;
    logic pwrite;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    int tests_run;
    int n_mismatch;

    core_model core (.core_clk_i(clk), .req_o(req));
    dmem_bank_core dut (.core_clk_i(clk), .rst_n_i(rst_n), .req_i(req),
        .rdata_o(rdata), .rvalid_o(rvalid), .addr_o(addr), .flags_o(flags),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .pwdata_i(pwdata), .pstrb_i(4'hF),
        .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr));

    initial
    begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [11:0] a,
        input logic [31:0] wd, output logic [31:0] rd, output logic err);
        int n;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        for (n = 0; n < 20; n++)
        begin
            @(posedge clk);
            if (pready === 1'b1)
                break;
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n == 20)
        begin
            n_mismatch++;
            report_and_stop();
        end
    endtask

    task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [11:0] a, input logic [31:0] ex,
        input logic ex_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        `CHK("pslverr", ex_err, err)
        if (!ex_err)
            `CHK("prdata", ex, rd)
    endtask

    function automatic dmem_pkg::core_req_t rq(input logic ab,
        input logic [7:0] off, input logic [7:0] wd, input logic wr);
        rq = '0;
        rq.access_bit = ab;
        rq.offset = off;
        rq.wdata = wd;
        rq.write = wr;
    endfunction

    // one access, then target address and read data one cycle later
    task automatic acc(input dmem_pkg::core_req_t r, input logic [11:0] ea,
        input logic [7:0] ed);
        core.send(r);
        #1;
        `CHK("addr_o", ea, addr)
        `CHK("rvalid_o", ~r.write, rvalid)
        if (!r.write)
            `CHK("rdata_o", ed, rdata)
    endtask

    task automatic t_regs();
        rd_chk(dmem_pkg::APB_BANK, 32'h0000_0000, 1'b0);
        rd_chk(dmem_pkg::APB_FLAGS, 32'h0000_0000, 1'b0);
        wr_reg(dmem_pkg::APB_BANK, 32'h0000_00FF);
        rd_chk(dmem_pkg::APB_BANK, 32'h0000_000F, 1'b0);
        rd_chk(12'h018, 32'h0000_0000, 1'b1);
    endtask

    task automatic t_direct();
        dmem_pkg::core_req_t r;
        wr_reg(dmem_pkg::APB_BANK, 32'h0000_0001);
        acc(rq(1'b1, 8'h34, 8'hA5, 1'b1), 12'h134, 8'h00);
        acc(rq(1'b1, 8'hFF, 8'h5C, 1'b1), 12'h1FF, 8'h00);
        acc(rq(1'b1, 8'h34, 8'h00, 1'b0), 12'h134, 8'hA5);
        acc(rq(1'b1, 8'hFF, 8'h00, 1'b0), 12'h1FF, 8'h5C);
        rd_chk(dmem_pkg::APB_LAST, 32'h0000_01FF, 1'b0);
        r = rq(1'b1, 8'h00, 8'h5A, 1'b1);
        r.move = 1'b1;
        r.full_addr = 12'h0AB;
        acc(r, 12'h0AB, 8'h00);
        wr_reg(dmem_pkg::APB_BANK, 32'h0000_0000);
        acc(rq(1'b1, 8'hAB, 8'h00, 1'b0), 12'h0AB, 8'h5A);
    endtask

    task automatic t_window();
        wr_reg(dmem_pkg::APB_BANK, 32'h0000_0001);
        acc(rq(1'b0, 8'h5F, 8'h3C, 1'b1), 12'h05F, 8'h00);
        acc(rq(1'b0, 8'h5F, 8'h00, 1'b0), 12'h05F, 8'h3C);
        acc(rq(1'b0, 8'h60, 8'h00, 1'b0), 12'hF60, 8'h00);
        wr_reg(dmem_pkg::APB_BANK, 32'h0000_0005);
        acc(rq(1'b1, 8'h10, 8'h77, 1'b1), 12'h510, 8'h00);
        acc(rq(1'b1, 8'h10, 8'h00, 1'b0), 12'h510, 8'h00);
    endtask

    task automatic t_pointer();
        dmem_pkg::core_req_t r;
        acc(rq(1'b0, 8'h00, 8'h22, 1'b1), 12'h000, 8'h00);
        wr_reg(dmem_pkg::APB_FLAGS, 32'h0000_0015);
        wr_reg(dmem_pkg::APB_PTR0, 32'h0000_00FF);
        acc(rq(1'b1, 8'hFF, 8'h44, 1'b1), 12'h5FF, 8'h00);
        wr_reg(dmem_pkg::APB_BANK, 32'h0000_0000);
        acc(rq(1'b1, 8'hFF, 8'h66, 1'b1), 12'h0FF, 8'h00);
        acc(rq(1'b0, 8'hD2, 8'h00, 1'b0), 12'h0FF, 8'h66);
        rd_chk(dmem_pkg::APB_PTR0, 32'h0000_0100, 1'b0);
        acc(rq(1'b0, 8'hD3, 8'h33, 1'b1), 12'h101, 8'h00);
        acc(rq(1'b0, 8'hD1, 8'h00, 1'b0), 12'h101, 8'h33);
        rd_chk(dmem_pkg::APB_PTR0, 32'h0000_0100, 1'b0);
        // accumulator of -1 steps back one byte from the pointer
        r = rq(1'b0, 8'hD4, 8'h00, 1'b0);
        r.accumulator = 8'hFF;
        acc(r, 12'h0FF, 8'h66);
        rd_chk(dmem_pkg::APB_PTR0, 32'h0000_0100, 1'b0);
        `CHK("flags_o", 8'h15, flags)
    endtask

    task automatic t_port_loop();
        wr_reg(dmem_pkg::APB_FLAGS, 32'h0000_0000);
        wr_reg(dmem_pkg::APB_PTR0 + 12'h004, 32'h0000_0FD0);
        acc(rq(1'b0, 8'hD8, 8'h00, 1'b0), 12'hFD0, 8'h00);
        `CHK("flags_o", 8'h04, flags)
        wr_reg(dmem_pkg::APB_FLAGS, 32'h0000_0001);
        acc(rq(1'b0, 8'hD8, 8'h99, 1'b1), 12'hFD0, 8'h00);
        `CHK("flags_o", 8'h01, flags)
        // pointer 0 aimed at its own low byte: post-increment loses
        wr_reg(dmem_pkg::APB_PTR0, 32'h0000_0FD5);
        acc(rq(1'b0, 8'hD2, 8'h44, 1'b1), 12'hFD5, 8'h00);
        rd_chk(dmem_pkg::APB_PTR0, 32'h0000_0F44, 1'b0);
    endtask

    task automatic alu(input dmem_pkg::alu_kind_t k, input logic [7:0] a,
        input logic [7:0] b, input logic [7:0] off, input logic [7:0] ef);
        dmem_pkg::core_req_t r;
        r = rq(1'b0, off, 8'h00, 1'b1);
        r.kind = k;
        r.opa = a;
        r.opb = b;
        r.result = a & b;
        core.send(r);
        #1;
        `CHK("flags_o", ef, flags)
    endtask

    task automatic t_flags();
        alu(dmem_pkg::ALU_ADD, 8'h7F, 8'h01, 8'h00, 8'h1A);
        alu(dmem_pkg::ALU_SUB, 8'h00, 8'h01, 8'h00, 8'h10);
        alu(dmem_pkg::ALU_SUB, 8'h05, 8'h05, 8'h00, 8'h07);
        alu(dmem_pkg::ALU_ROTL, 8'h88, 8'h00, 8'h00, 8'h03);
        alu(dmem_pkg::ALU_ROTR, 8'h11, 8'h00, 8'h00, 8'h13);
        alu(dmem_pkg::ALU_LOGIC, 8'hF0, 8'h0F, 8'h00, 8'h07);
        alu(dmem_pkg::ALU_ADD, 8'h7F, 8'h01, 8'hE8, 8'h1A);
    endtask

    initial
    begin
        tests_run = 0;
        n_mismatch = 0;
        rst_n = 1'b0;
        paddr = '0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = '0;
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        t_regs();
        t_direct();
        t_window();
        t_pointer();
        t_port_loop();
        t_flags();
        report_and_stop();
    end
endmodule // tb_data_memory_banking_indirect_status
